// ### shared/spc_defines.svh
// constants of the segment privilege checker: register map, field positions, codes
// assumes inclusion by the checker module and its bench; definitions only
//
// Summary of operation
// - selector splits into table indicator, 13-bit index and requestor level
// - every segment register load fetches the 8-byte descriptor; only a fault-free load writes it into its cache
// - references use the cached descriptor; cache changes only on reload
// - four privilege levels 0..3, 0 most privileged
// - data segment level p reachable only from level p or more privileged
// - code segment level p callable only from level p or less privileged
// - current level changes only through a gate into another level
// - effective level is the larger of current and requestor levels
// - adjust-requestor instruction forces requestor bits to originator's level
// - io level field sits in flags word bits 13 and 14
// - io-sensitive instructions fault 13 when current level exceeds io level
// - data register loads accept data or readable code segments only
// - data register load faults 13 when effective level beats descriptor level
// - stack register load accepts writable data segments only
// - stack load needs descriptor and requestor level equal current, else 13
// - stack load of a not-present descriptor raises 12
// - control transfer with wrong descriptor type raises 13
// - transfer kinds pair with descriptor types and tables as listed
// - interrupt return is plain return when nested flag 0, task gate when 1
// - gate word count copies 16-bit units legacy, 32-bit units native
// - legacy descriptors give 24-bit base, 16-bit limit; native 32/20 plus G
// - not-present descriptor on access raises 11, stack case 12
// - descriptor level is a two-bit field, not compared for task state, task gate or interrupt gate transfers
`ifndef SPC_DEFINES_SVH
`define SPC_DEFINES_SVH

// ------------------------------------------------
// register map (byte offsets)
// ------------------------------------------------
`define SPC_REG_FLAGS 8'h00
`define SPC_REG_GBASE 8'h04
`define SPC_REG_LBASE 8'h08
`define SPC_REG_IBASE 8'h0c
`define SPC_REG_STATUS 8'h10
`define SPC_REG_CSEL 8'h14
`define SPC_REG_CBASE 8'h18
`define SPC_REG_CLIMIT 8'h1c

// ------------------------------------------------
// fields and codes
// ------------------------------------------------
`define SPC_IOLVL_LO 13
`define SPC_IOLVL_HI 14
`define SPC_NEST_BIT 15
`define SPC_SEL_TBL 2
`define SPC_SEL_IX_HI 15
`define SPC_SEL_IX_LO 3
`define SPC_SEL_RQ_HI 1
`define SPC_SEL_RQ_LO 0
`define SPC_D_TYPE_LO 40
`define SPC_D_TYPE_HI 43
`define SPC_D_S 44
`define SPC_D_LVL_LO 45
`define SPC_D_LVL_HI 46
`define SPC_D_P 47
`define SPC_D_G 55
`define SPC_D_WC_LO 32
`define SPC_D_WC_HI 36
`define SPC_TY_CODE 3
`define SPC_TY_CONF 2
`define SPC_TY_RW 1
`define SPC_T_TSTATE16 4'h1
`define SPC_T_TSTATE32 4'h9
`define SPC_T_CG16 4'h4
`define SPC_T_CG32 4'hc
`define SPC_T_TGATE 4'h5
`define SPC_T_IG16 4'h6
`define SPC_T_TR16 4'h7
`define SPC_T_IG32 4'he
`define SPC_T_TR32 4'hf
`define SPC_VEC_GP 8'h0d
`define SPC_VEC_SS 8'h0c
`define SPC_VEC_NP 8'h0b
`define SPC_SEG_CODE 3'h0
`define SPC_SEG_STACK 3'h1
`define SPC_SEG_LAST 3'h5
`define SPC_NSEG 6

`endif

// ### shared/spc_pkg.sv
// types shared by the segment privilege checker and its bench
// assumes nothing beyond a SystemVerilog compiler
package spc_pkg;

	typedef enum logic [1:0] {SPC_IDLE = 2'b01, SPC_FETCH = 2'b10} spc_state_t;

	// operations offered by the execution pipeline
	typedef enum logic [2:0] {
		SPC_OP_LOAD = 3'h0,
		SPC_OP_XFER = 3'h1,
		SPC_OP_ACCESS = 3'h2,
		SPC_OP_IO = 3'h3,
		SPC_OP_ADJ = 3'h4
	} spc_op_t;

	// kinds of inter-segment transfer
	typedef enum logic [2:0] {
		SPC_K_JMP = 3'h0,
		SPC_K_CALL = 3'h1,
		SPC_K_RET = 3'h2,
		SPC_K_IRET = 3'h3,
		SPC_K_INT = 3'h4
	} spc_kind_t;

endpackage : spc_pkg

// ### hw/spc_checker.sv
// segment privilege checker: selector decode, descriptor caches, privilege checks
// assumes the pipeline and memory port run on core_clk; Avalon-MM register slave
`timescale 1ns/1ps
`include "spc_defines.svh"
module spc_checker import spc_pkg::*;
(
	// clock and reset
	input logic core_clk,
	input logic nrst,
	// register bus
	input logic [7:0] avs_address,
	input logic avs_read,
	input logic avs_write,
	input logic [31:0] avs_writedata,
	input logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// pipeline request
	input logic op_valid,
	input spc_op_t op_code,
	input logic [2:0] op_seg,
	input spc_kind_t op_kind,
	input logic [15:0] op_selector,
	input logic [1:0] op_level,
	// descriptor fetch
	output logic mem_req,
	output logic [31:0] mem_addr,
	input logic [63:0] mem_rdata,
	input logic mem_valid,
	// pipeline answer
	output logic done,
	output logic fault,
	output logic [7:0] fault_vector,
	output logic [15:0] result_word,
	output logic [4:0] param_count,
	output logic param_wide,
	output logic [1:0] current_level
);

	// ------------------------------------------------
	// state
	// ------------------------------------------------
	spc_state_t state;
	spc_op_t r_op;
	spc_kind_t r_kind;
	logic [2:0] r_seg;
	logic [15:0] r_sel;
	logic [1:0] r_lvl;
	logic [31:0] flags_word;
	logic [31:0] gbase;
	logic [31:0] lbase;
	logic [31:0] ibase;
	logic [2:0] cache_sel;
	logic [7:0] last_vector;
	logic [63:0] seg_cache [0:`SPC_NSEG-1];

	// ------------------------------------------------
	// request decode
	// ------------------------------------------------
	wire idle = (state == SPC_IDLE);
	wire take = idle & op_valid;
	wire needs_fetch = (op_code == SPC_OP_LOAD) | (op_code == SPC_OP_XFER);
	wire fin_idle = take & ~needs_fetch;
	wire fin_fetch = (state == SPC_FETCH) & mem_valid;
	wire [1:0] io_level_field = flags_word[`SPC_IOLVL_HI:`SPC_IOLVL_LO];
	wire nested_task_flag = flags_word[`SPC_NEST_BIT];
	wire table_indicator = op_selector[`SPC_SEL_TBL];
	wire [12:0] sel_index = op_selector[`SPC_SEL_IX_HI:`SPC_SEL_IX_LO];
	wire is_int = (op_code == SPC_OP_XFER) & (op_kind == SPC_K_INT);
	wire [31:0] tbase = is_int ? ibase : (table_indicator ? lbase : gbase);
	wire [31:0] next_addr = tbase + {16'h0000, sel_index, 3'h0};

	// ------------------------------------------------
	// fetched descriptor decode
	// ------------------------------------------------
	wire [3:0] d_type = mem_rdata[`SPC_D_TYPE_HI:`SPC_D_TYPE_LO];
	wire d_s = mem_rdata[`SPC_D_S];
	wire d_p = mem_rdata[`SPC_D_P];
	wire [1:0] segment_level = mem_rdata[`SPC_D_LVL_HI:`SPC_D_LVL_LO];
	wire [1:0] requestor_level = r_sel[`SPC_SEL_RQ_HI:`SPC_SEL_RQ_LO];
	wire r_ti = r_sel[`SPC_SEL_TBL];
	// larger number is less privileged
	wire [1:0] effective_level = (current_level > requestor_level) ?
		current_level : requestor_level;
	wire is_code = d_s & d_type[`SPC_TY_CODE];
	wire is_data = d_s & ~d_type[`SPC_TY_CODE];
	wire is_tss = ~d_s & ((d_type == `SPC_T_TSTATE16) | (d_type == `SPC_T_TSTATE32));
	wire is_cgate = ~d_s & ((d_type == `SPC_T_CG16) | (d_type == `SPC_T_CG32));
	wire is_tgate = ~d_s & (d_type == `SPC_T_TGATE);
	wire is_igate = ~d_s & ((d_type == `SPC_T_IG16) | (d_type == `SPC_T_TR16) |
		(d_type == `SPC_T_IG32) | (d_type == `SPC_T_TR32));

	// data and stack register loads
	wire ld_stack = (r_seg == `SPC_SEG_STACK);
	wire data_type_ok = is_data | (is_code & d_type[`SPC_TY_RW]);
	wire data_priv_ok = (effective_level <= segment_level);
	wire stack_ok = is_data & d_type[`SPC_TY_RW] & (segment_level == current_level) &
		(requestor_level == current_level);
	wire load_ok = ld_stack ? stack_ok : (data_type_ok & data_priv_ok);

	// transfer pairings
	wire code_same = is_code & (d_type[`SPC_TY_CONF] ? (segment_level <= current_level) :
		(segment_level == current_level));
	wire tss_ok = is_tss & ~r_ti;
	wire gate_ok = is_cgate & (r_lvl <= current_level) &
		(effective_level <= segment_level);
	wire code_ret = is_code & (segment_level >= current_level);
	wire xfer_ok = (r_kind == SPC_K_JMP) ? (code_same | tss_ok | is_tgate) :
		(r_kind == SPC_K_CALL) ? (code_same | gate_ok | tss_ok | is_tgate) :
		(r_kind == SPC_K_RET) ? code_ret :
		(r_kind == SPC_K_IRET) ? (nested_task_flag ? is_tgate : code_ret) :
		(r_kind == SPC_K_INT) ? (is_igate | is_tgate) : 1'b0;
	wire fetch_seg_ok = (r_op == SPC_OP_XFER) | (r_seg <= `SPC_SEG_LAST);
	// a bad slot is a general fault, never a not-present one
	wire fetch_gp = ((r_op == SPC_OP_LOAD) ? ~load_ok : ~xfer_ok) | ~fetch_seg_ok;
	wire fetch_np = ~d_p;
	wire fetch_fault = fetch_gp | fetch_np;
	wire [7:0] fetch_vec = fetch_gp ? `SPC_VEC_GP :
		((r_op == SPC_OP_LOAD) & ld_stack) ? `SPC_VEC_SS : `SPC_VEC_NP;
	wire [2:0] cache_slot = (r_op == SPC_OP_XFER) ? `SPC_SEG_CODE : r_seg;
	// level moves only through a gate into a different level
	wire lvl_change = fin_fetch & ~fetch_fault & (r_op == SPC_OP_XFER) &
		(is_cgate | is_igate) & (r_lvl != current_level);

	// ------------------------------------------------
	// answers that need no fetch
	// ------------------------------------------------
	wire seg_in_range = (op_seg <= `SPC_SEG_LAST);
	wire [63:0] acc_desc = seg_in_range ? seg_cache[op_seg] : 64'h0000_0000_0000_0000;
	wire acc_np = ~acc_desc[`SPC_D_P];
	wire acc_data = acc_desc[`SPC_D_S] & ~acc_desc[`SPC_D_TYPE_HI];
	wire acc_priv_bad = acc_data &
		(current_level > acc_desc[`SPC_D_LVL_HI:`SPC_D_LVL_LO]);
	wire io_bad = (current_level > io_level_field);
	wire idle_fault = (op_code == SPC_OP_IO) ? io_bad :
		(op_code == SPC_OP_ACCESS) ? (~seg_in_range | acc_np | acc_priv_bad) : 1'b0;
	wire [7:0] idle_vec = ((op_code == SPC_OP_ACCESS) & seg_in_range & acc_np) ?
		((op_seg == `SPC_SEG_STACK) ? `SPC_VEC_SS : `SPC_VEC_NP) : `SPC_VEC_GP;
	wire [15:0] adj_word = {op_selector[`SPC_SEL_IX_HI:`SPC_SEL_TBL], op_level};

	// ------------------------------------------------
	// sequencing
	// ------------------------------------------------
	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
			state <= SPC_IDLE;
		else if (take & needs_fetch)
			state <= SPC_FETCH;
		else if (fin_fetch)
			state <= SPC_IDLE;
	end

	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			r_op <= SPC_OP_LOAD;
			r_kind <= SPC_K_JMP;
			r_seg <= 3'h0;
			r_sel <= 16'h0000;
			r_lvl <= 2'h0;
		end
		else if (take)
		begin
			r_op <= op_code;
			r_kind <= op_kind;
			r_seg <= op_seg;
			r_sel <= op_selector;
			r_lvl <= op_level;
		end
	end

	// request held until the descriptor returns
	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			mem_req <= 1'b0;
			mem_addr <= 32'h0000_0000;
		end
		else if (take & needs_fetch)
		begin
			mem_req <= 1'b1;
			mem_addr <= next_addr;
		end
		else if (fin_fetch)
			mem_req <= 1'b0;
	end

	// one fault event per instruction, done raised in the same cycle as the fault
	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			done <= 1'b0;
			fault <= 1'b0;
			fault_vector <= 8'h00;
		end
		else
		begin
			done <= fin_idle | fin_fetch;
			fault <= (fin_idle & idle_fault) | (fin_fetch & (fetch_fault | ~fetch_seg_ok));
			fault_vector <= fin_idle ? idle_vec : (fin_fetch ? fetch_vec : 8'h00);
		end
	end

	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			result_word <= 16'h0000;
			param_count <= 5'h00;
			param_wide <= 1'b0;
		end
		else if (fin_idle & (op_code == SPC_OP_ADJ))
			result_word <= adj_word;
		else if (fin_fetch & is_cgate)
		begin
			param_count <= mem_rdata[`SPC_D_WC_HI:`SPC_D_WC_LO];
			param_wide <= d_type[`SPC_TY_CODE];
		end
	end

	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
			current_level <= 2'h0;
		else if (lvl_change)
			current_level <= r_lvl;
	end

	// cache written only on a successful reload
	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			for (int i = 0; i < `SPC_NSEG; i++)
				seg_cache[i] <= 64'h0000_0000_0000_0000;
		end
		else if (fin_fetch & ~fetch_fault & fetch_seg_ok)
			seg_cache[cache_slot] <= mem_rdata;
	end

	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
			last_vector <= 8'h00;
		else if ((fin_idle & idle_fault) | (fin_fetch & fetch_fault))
			last_vector <= fin_idle ? idle_vec : fetch_vec;
	end

	// ------------------------------------------------
	// register slave, one wait state per access
	// ------------------------------------------------
	function automatic logic [31:0] spc_merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++)
			if (be[b])
				r[b*8 +: 8] = nw[b*8 +: 8];
		return r;
	endfunction : spc_merge

	wire bus_req = avs_read | avs_write;
	wire wr_now = avs_write & ~avs_waitrequest;
	wire [63:0] sel_desc = (cache_sel <= `SPC_SEG_LAST) ? seg_cache[cache_sel] :
		64'h0000_0000_0000_0000;
	// legacy form is marked by an all-zero upper word
	wire legacy = (sel_desc[63:48] == 16'h0000);
	wire [31:0] dec_base = legacy ? {8'h00, sel_desc[39:16]} :
		{sel_desc[63:56], sel_desc[39:16]};
	wire [31:0] dec_limit = legacy ? {16'h0000, sel_desc[15:0]} :
		{sel_desc[`SPC_D_G], 11'h000, sel_desc[51:48], sel_desc[15:0]};
	wire [31:0] status_word = {16'h0000, last_vector, 4'h0, ~idle, 1'b0, current_level};
	wire [31:0] rd_mux = (avs_address == `SPC_REG_FLAGS) ? flags_word :
		(avs_address == `SPC_REG_GBASE) ? gbase :
		(avs_address == `SPC_REG_LBASE) ? lbase :
		(avs_address == `SPC_REG_IBASE) ? ibase :
		(avs_address == `SPC_REG_STATUS) ? status_word :
		(avs_address == `SPC_REG_CSEL) ? {29'h000_0000, cache_sel} :
		(avs_address == `SPC_REG_CBASE) ? dec_base :
		(avs_address == `SPC_REG_CLIMIT) ? dec_limit : 32'h0000_0000;

	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			avs_waitrequest <= 1'b1;
			avs_readdata <= 32'h0000_0000;
		end
		else
		begin
			avs_waitrequest <= ~(bus_req & avs_waitrequest);
			if (avs_read & avs_waitrequest)
				avs_readdata <= rd_mux;
		end
	end

	// reloading a segment register is the only way software sees table edits
	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			flags_word <= 32'h0000_0000;
			gbase <= 32'h0000_0000;
			lbase <= 32'h0000_0000;
			ibase <= 32'h0000_0000;
			cache_sel <= 3'h0;
		end
		else if (wr_now)
		begin
			if (avs_address == `SPC_REG_FLAGS)
				flags_word <= spc_merge(flags_word, avs_writedata, avs_byteenable);
			if (avs_address == `SPC_REG_GBASE)
				gbase <= spc_merge(gbase, avs_writedata, avs_byteenable);
			if (avs_address == `SPC_REG_LBASE)
				lbase <= spc_merge(lbase, avs_writedata, avs_byteenable);
			if (avs_address == `SPC_REG_IBASE)
				ibase <= spc_merge(ibase, avs_writedata, avs_byteenable);
			if ((avs_address == `SPC_REG_CSEL) & avs_byteenable[0])
				cache_sel <= avs_writedata[2:0];
		end
	end

	// ------------------------------------------------
	// checks
	// ------------------------------------------------
	default clocking @(posedge core_clk); endclocking
	default disable iff (!nrst);

	property p_io_fault;
		take & (op_code == SPC_OP_IO) & (current_level > io_level_field)
			|=> done & fault & (fault_vector == `SPC_VEC_GP);
	endproperty
	a_io_fault: assert property (p_io_fault) else $error("io check missed");

	property p_io_pass;
		take & (op_code == SPC_OP_IO) & (current_level <= io_level_field) |=> done & ~fault;
	endproperty
	a_io_pass: assert property (p_io_pass) else $error("io check false fault");

	property p_fetch_hold;
		(take & needs_fetch) | (mem_req & ~mem_valid) |=> mem_req;
	endproperty
	a_fetch_hold: assert property (p_fetch_hold) else $error("fetch dropped");

	property p_no_refetch;
		~(take & needs_fetch) |=> ~$rose(mem_req);
	endproperty
	a_no_refetch: assert property (p_no_refetch) else $error("access refetched");

	property p_data_priv;
		fin_fetch & (r_op == SPC_OP_LOAD) & ~ld_stack & data_type_ok & d_p &
			(effective_level > segment_level) |=> fault & (fault_vector == `SPC_VEC_GP);
	endproperty
	a_data_priv: assert property (p_data_priv) else $error("data privilege missed");

	property p_stack_np;
		fin_fetch & (r_op == SPC_OP_LOAD) & ld_stack & stack_ok & ~d_p
			|=> fault & (fault_vector == `SPC_VEC_SS);
	endproperty
	a_stack_np: assert property (p_stack_np) else $error("stack not present vector");

	property p_level_cause;
		(current_level != $past(current_level)) |-> $past(lvl_change);
	endproperty
	a_level_cause: assert property (p_level_cause) else $error("level moved");

	property p_adjust;
		take & (op_code == SPC_OP_ADJ)
			|=> done & ~fault & (result_word[1:0] == $past(op_level));
	endproperty
	a_adjust: assert property (p_adjust) else $error("adjust result wrong");

	property p_iret_nested;
		fin_fetch & (r_op == SPC_OP_XFER) & (r_kind == SPC_K_IRET) & nested_task_flag &
			is_code |=> fault & (fault_vector == `SPC_VEC_GP);
	endproperty
	a_iret_nested: assert property (p_iret_nested) else $error("nested return type");

	property p_fault_event;
		fault |-> done ##1 ~fault;
	endproperty
	a_fault_event: assert property (p_fault_event) else $error("fault not single");

endmodule : spc_checker

// ### tb/spc_mem_model.sv
// memory side stand-in: answers descriptor fetches after a wait set by the bench
// assumes the bench places each descriptor in mem before the fetch that reads it
`timescale 1ns/1ps
module spc_mem_model
(
	// clock and reset
	input wire logic core_clk,
	input wire logic nrst,
	// fetch port
	input wire logic mem_req,
	input wire logic [31:0] mem_addr,
	output logic mem_valid,
	output logic [63:0] mem_rdata,
	// bench control and observation
	input wire logic [1:0] wait_cycles,
	output int fetches,
	output logic [31:0] last_addr
);
	logic [63:0] mem [logic [31:0]];
	logic [1:0] cnt;

	// idle data toggles every cycle so a stale sample never looks right
	always @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			mem_valid <= 1'b0;
			mem_rdata <= 64'h5a5a_5a5a_5a5a_5a5a;
			cnt <= 2'h0;
			fetches <= 0;
			last_addr <= 32'h0000_0000;
		end
		else if (mem_valid)
		begin
			mem_valid <= 1'b0;
			mem_rdata <= ~mem_rdata;
			cnt <= 2'h0;
		end
		else if (mem_req && cnt >= wait_cycles)
		begin
			mem_valid <= 1'b1;
			mem_rdata <= mem[mem_addr]; // whole 8-byte descriptor in one beat
			fetches <= fetches + 1;
			last_addr <= mem_addr;
		end
		else
		begin
			mem_rdata <= ~mem_rdata;
			cnt <= mem_req ? cnt + 2'h1 : 2'h0;
		end
	end
endmodule : spc_mem_model

// ### tb/segment_privilege_checker_tb_top.sv
// self-checking bench of the segment privilege checker
// assumes spc_checker and spc_mem_model; one clock, registers over Avalon-MM
`timescale 1ns/1ps
`include "spc_defines.svh"
module segment_privilege_checker_tb_top import spc_pkg::*;
;
	logic core_clk = 1'b0;
	logic nrst = 1'b0;
	logic [7:0] avs_address = 8'h00;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0000_0000;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic op_valid = 1'b0;
	spc_op_t op_code = SPC_OP_IO;
	logic [2:0] op_seg = 3'h0;
	spc_kind_t op_kind = SPC_K_JMP;
	logic [15:0] op_selector = 16'h0000;
	logic [1:0] op_level = 2'h0;
	logic mem_req, mem_valid, done, fault, param_wide;
	logic [31:0] mem_addr, last_addr;
	logic [63:0] mem_rdata;
	logic [7:0] fault_vector;
	logic [15:0] result_word;
	logic [4:0] param_count;
	logic [1:0] current_level;
	logic [1:0] wait_cycles = 2'h0;
	int fetches, mismatches = 0, checked = 0, seed = 32'hf2d2;
	logic [31:0] q;
	int f0;
	logic [15:0] hi = 16'h0000;

	always #10 core_clk = ~core_clk;

	spc_checker i_dut (.core_clk(core_clk), .nrst(nrst), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(4'hf), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.op_valid(op_valid), .op_code(op_code), .op_seg(op_seg), .op_kind(op_kind),
		.op_selector(op_selector), .op_level(op_level), .mem_req(mem_req), .mem_addr(mem_addr),
		.mem_rdata(mem_rdata), .mem_valid(mem_valid), .done(done), .fault(fault),
		.fault_vector(fault_vector), .result_word(result_word), .param_count(param_count),
		.param_wide(param_wide), .current_level(current_level));

	spc_mem_model i_mem (.core_clk(core_clk), .nrst(nrst), .mem_req(mem_req),
		.mem_addr(mem_addr), .mem_valid(mem_valid), .mem_rdata(mem_rdata),
		.wait_cycles(wait_cycles), .fetches(fetches), .last_addr(last_addr));

	// ------------------------------------------------
	// checking and closing
	// ------------------------------------------------
	task end_sim;
		if (mismatches == 0 && checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : end_sim

	task chk(input logic ok, input string m);
		checked++;
		if (ok !== 1'b1)
		begin
			mismatches++;
			$display("[FAIL] %0t %s", $time, m);
		end
	endtask : chk

	function automatic logic [31:0] tbase(input logic [1:0] t);
		return t == 2'd0 ? 32'h0000_1000 : (t == 2'd1 ? 32'h0000_2000 : 32'h0000_3000);
	endfunction : tbase

	function automatic logic [63:0] dsc(input logic [3:0] ty, input logic s,
		input logic [1:0] dl, input logic p, input logic [4:0] wc);
		logic [63:0] d;
		d = 64'h0000_0000_0000_ffff;
		d[43:40] = ty;
		d[44] = s;
		d[46:45] = dl;
		d[47] = p;
		d[36:32] = wc;
		d[63:48] = hi;
		return d;
	endfunction : dsc

	// ------------------------------------------------
	// bus master and pipeline driver
	// ------------------------------------------------
	task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge core_clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= wr;
		avs_read <= !wr;
		for (n = 0; n < 40; n++)
		begin
			@(posedge core_clk);
			if (avs_waitrequest === 1'b0)
				break;
		end
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		if (n == 40)
		begin
			chk(1'b0, "bus wait ran out");
			end_sim();
		end
	endtask : bus

	task rd(input logic [7:0] a, input logic [31:0] e, input string m);
		bus(1'b0, a, 32'h0000_0000);
		chk(q === e, m);
	endtask : rd

	task op(input spc_op_t c, input logic [2:0] sg, input spc_kind_t k, input logic [15:0] s,
		input logic [1:0] l, input logic ef, input logic [7:0] ev, input string m);
		int n;
		@(posedge core_clk);
		op_code <= c;
		op_seg <= sg;
		op_kind <= k;
		op_selector <= s;
		op_level <= l;
		op_valid <= 1'b1;
		wait_cycles <= 2'($random(seed));
		@(posedge core_clk);
		op_valid <= 1'b0;
		for (n = 0; n < 40; n++)
		begin
			@(posedge core_clk);
			if (done === 1'b1)
				break;
		end
		if (n == 40)
		begin
			chk(1'b0, "no done");
			end_sim();
		end
		chk(fault === ef && (!ef || fault_vector === ev), m);
	endtask : op

	// load through the global or local table at a random index
	task ld(input logic [2:0] sg, input logic [3:0] ty, input logic s, input logic [1:0] dl,
		input logic p, input logic [1:0] rq, input logic ef, input logic [7:0] ev);
		logic [12:0] ix;
		logic ti;
		ix = 13'($random(seed));
		ti = 1'($random(seed));
		i_mem.mem[tbase({1'b0, ti}) + {16'h0, ix, 3'b000}] = dsc(ty, s, dl, p, 5'h00);
		op(SPC_OP_LOAD, sg, SPC_K_JMP, {ix, ti, rq}, 2'h0, ef, ev, "segment load");
		chk(last_addr === tbase({1'b0, ti}) + {16'h0, ix, 3'b000}, "fetch address");
	endtask : ld

	task xf(input spc_kind_t k, input logic [1:0] t, input logic [3:0] ty, input logic s,
		input logic [1:0] dl, input logic [4:0] wc, input logic [1:0] rq, input logic [1:0] l,
		input logic ef);
		logic [12:0] ix;
		ix = 13'($random(seed)) & 13'h00ff;
		i_mem.mem[tbase(t) + {16'h0, ix, 3'b000}] = dsc(ty, s, dl, 1'b1, wc);
		op(SPC_OP_XFER, 3'h0, k, {ix, t == 2'd1, rq}, l, ef, `SPC_VEC_GP, "transfer");
	endtask : xf

	task flags(input logic [1:0] io, input logic nt);
		logic [12:0] r;
		r = 13'($random(seed));
		bus(1'b1, `SPC_REG_FLAGS, {16'h0000, nt, io, r});
		bus(1'b0, `SPC_REG_FLAGS, 32'h0000_0000);
		chk(q[15:0] === {nt, io, r}, "flags readback");
	endtask : flags

	// ------------------------------------------------
	// main sequence
	// ------------------------------------------------
	initial
	begin
		repeat (6) @(posedge core_clk);
		nrst <= 1'b1;
		bus(1'b0, `SPC_REG_STATUS, 32'h0000_0000);
		chk(q[1:0] === 2'h0 && current_level === 2'h0, "reset level");
		bus(1'b1, `SPC_REG_GBASE, tbase(2'd0));
		bus(1'b1, `SPC_REG_LBASE, tbase(2'd1));
		bus(1'b1, `SPC_REG_IBASE, tbase(2'd2));
		bus(1'b0, `SPC_REG_LBASE, 32'h0000_0000);
		chk(q === tbase(2'd1), "base readback");
		bus(1'b0, 8'h40, 32'h0000_0000);
		chk(q === 32'h0000_0000, "unmapped read");
		flags(2'h0, 1'b0);
		op(SPC_OP_IO, 3'h0, SPC_K_JMP, 16'h0000, 2'h0, 1'b0, 8'h00, "io at level 0");
		ld(3'h2, 4'h2, 1'b1, 2'h0, 1'b1, 2'h0, 1'b0, 8'h00);
		ld(3'h3, 4'ha, 1'b1, 2'h3, 1'b1, 2'h0, 1'b0, 8'h00);
		ld(3'h4, 4'h8, 1'b1, 2'h0, 1'b1, 2'h0, 1'b1, `SPC_VEC_GP);
		ld(3'h5, `SPC_T_CG32, 1'b0, 2'h0, 1'b1, 2'h0, 1'b1, `SPC_VEC_GP);
		ld(3'h2, 4'h2, 1'b1, 2'h0, 1'b1, 2'h3, 1'b1, `SPC_VEC_GP);
		ld(3'h4, 4'h2, 1'b1, 2'h0, 1'b0, 2'h0, 1'b1, `SPC_VEC_NP);
		ld(3'h1, 4'h2, 1'b1, 2'h0, 1'b1, 2'h0, 1'b0, 8'h00);
		ld(3'h1, 4'h0, 1'b1, 2'h0, 1'b1, 2'h0, 1'b1, `SPC_VEC_GP);
		ld(3'h1, 4'ha, 1'b1, 2'h0, 1'b1, 2'h0, 1'b1, `SPC_VEC_GP);
		ld(3'h1, 4'h2, 1'b1, 2'h1, 1'b1, 2'h0, 1'b1, `SPC_VEC_GP);
		ld(3'h1, 4'h2, 1'b1, 2'h0, 1'b1, 2'h2, 1'b1, `SPC_VEC_GP);
		ld(3'h1, 4'h2, 1'b1, 2'h0, 1'b0, 2'h0, 1'b1, `SPC_VEC_SS);
		hi = 16'hc385;
		ld(3'h3, 4'h2, 1'b1, 2'h3, 1'b1, 2'h0, 1'b0, 8'h00);
		hi = 16'h0000;
		bus(1'b1, `SPC_REG_CSEL, 32'h0000_0003);
		rd(`SPC_REG_CBASE, 32'hc300_0000, "native base");
		rd(`SPC_REG_CLIMIT, 32'h8005_ffff, "native limit");
		bus(1'b1, `SPC_REG_CSEL, 32'h0000_0002);
		rd(`SPC_REG_CLIMIT, 32'h0000_ffff, "legacy limit");
		ld(3'h6, 4'h2, 1'b1, 2'h0, 1'b1, 2'h0, 1'b1, `SPC_VEC_GP);
		op(SPC_OP_ACCESS, 3'h4, SPC_K_JMP, 16'h0000, 2'h0, 1'b1, `SPC_VEC_NP, "absent");
		op(SPC_OP_ACCESS, 3'h6, SPC_K_JMP, 16'h0000, 2'h0, 1'b1, `SPC_VEC_GP, "bad slot");
		f0 = fetches;
		op(SPC_OP_ACCESS, 3'h2, SPC_K_JMP, 16'h0000, 2'h0, 1'b0, 8'h00, "cached access");
		chk(fetches === f0, "access refetched");
		xf(SPC_K_JMP, 2'd0, 4'ha, 1'b1, 2'h0, 5'h00, 2'h0, 2'h0, 1'b0);
		xf(SPC_K_JMP, 2'd1, 4'h2, 1'b1, 2'h0, 5'h00, 2'h0, 2'h0, 1'b1);
		xf(SPC_K_CALL, 2'd1, `SPC_T_CG32, 1'b0, 2'h0, 5'h05, 2'h0, 2'h0, 1'b0);
		chk(param_count === 5'h05 && param_wide === 1'b1, "native gate count");
		xf(SPC_K_CALL, 2'd0, `SPC_T_CG16, 1'b0, 2'h0, 5'h1f, 2'h0, 2'h0, 1'b0);
		chk(param_count === 5'h1f && param_wide === 1'b0, "legacy gate count");
		xf(SPC_K_JMP, 2'd1, `SPC_T_TSTATE32, 1'b0, 2'h0, 5'h00, 2'h0, 2'h0, 1'b1);
		xf(SPC_K_JMP, 2'd0, `SPC_T_TSTATE16, 1'b0, 2'h0, 5'h00, 2'h0, 2'h0, 1'b0);
		xf(SPC_K_CALL, 2'd1, `SPC_T_TGATE, 1'b0, 2'h0, 5'h00, 2'h0, 2'h0, 1'b0);
		flags(2'h0, 1'b1);
		xf(SPC_K_IRET, 2'd0, `SPC_T_TGATE, 1'b0, 2'h0, 5'h00, 2'h0, 2'h0, 1'b0);
		xf(SPC_K_IRET, 2'd0, 4'ha, 1'b1, 2'h0, 5'h00, 2'h0, 2'h0, 1'b1);
		flags(2'h0, 1'b0);
		xf(SPC_K_IRET, 2'd0, 4'ha, 1'b1, 2'h0, 5'h00, 2'h0, 2'h0, 1'b0);
		xf(SPC_K_IRET, 2'd0, `SPC_T_TGATE, 1'b0, 2'h0, 5'h00, 2'h0, 2'h0, 1'b1);
		xf(SPC_K_INT, 2'd2, `SPC_T_TR32, 1'b0, 2'h3, 5'h00, 2'h0, 2'h3, 1'b0);
		chk(current_level === 2'h3, "gate level change");
		for (int i = 0; i < 4; i++)
		begin
			flags(2'(i), 1'b0);
			op(SPC_OP_IO, 3'h0, SPC_K_JMP, 16'h0000, 2'h0, i < 3, `SPC_VEC_GP, "io check");
		end
		op(SPC_OP_ACCESS, 3'h2, SPC_K_JMP, 16'h0000, 2'h0, 1'b1, `SPC_VEC_GP, "data deny");
		op(SPC_OP_ACCESS, 3'h3, SPC_K_JMP, 16'h0000, 2'h0, 1'b0, 8'h00, "data allow");
		ld(3'h5, 4'h2, 1'b1, 2'h2, 1'b1, 2'h0, 1'b1, `SPC_VEC_GP);
		xf(SPC_K_CALL, 2'd0, 4'he, 1'b1, 2'h0, 5'h00, 2'h3, 2'h0, 1'b0);
		xf(SPC_K_CALL, 2'd0, 4'ha, 1'b1, 2'h0, 5'h00, 2'h3, 2'h0, 1'b1);
		xf(SPC_K_RET, 2'd1, 4'ha, 1'b1, 2'h3, 5'h00, 2'h3, 2'h0, 1'b0);
		chk(current_level === 2'h3, "level held");
		xf(SPC_K_CALL, 2'd0, `SPC_T_CG32, 1'b0, 2'h3, 5'h02, 2'h3, 2'h0, 1'b0);
		bus(1'b0, `SPC_REG_STATUS, 32'h0000_0000);
		chk(current_level === 2'h0 && q[1:0] === 2'h0, "call gate level");
		for (int i = 0; i < 6; i++)
		begin
			f0 = 1 + i % 3;
			q = $random(seed);
			op(SPC_OP_ADJ, 3'h0, SPC_K_JMP, {q[15:2], 2'h0}, 2'(f0), 1'b0, 8'h00, "adjust");
			chk(result_word === {q[15:2], 2'(f0)}, "adjusted selector");
		end
		end_sim();
	end
endmodule : segment_privilege_checker_tb_top
